/* hdl/evpr_cfg.svh */
`ifndef EVPR_CFG_SVH
`define EVPR_CFG_SVH
// Contract
// - Interrupt n maps to vector n+16 at table offset 4*(n+16); sources 0..43.
// - Table entry zero is the initial stack pointer; others are handler addresses.
// - After reset the vector table base is address zero.
// - Software may relocate the base within 0x100..0x3FFFFF00; fetches follow it.
// - Smaller priority value wins; all but reset, hard fault, NMI configurable.
// - Configurable priorities reset to zero.
// - Configurable priorities are three-bit values 0 to 7.
// - Reset, hard fault and NMI always outrank configurable exceptions.
// - Fixed priorities: reset -3, NMI -2, hard fault -1; NMI never masked.
// - Equal priorities resolve to the lowest exception number.
// - Strictly higher priority new exception preempts the running handler.
// - Equal priority never preempts; the new exception just stays pending.
// - Each exception is inactive, pending, active or active-and-pending.

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define EVPR_OFS_VBOR 8'h00
`define EVPR_OFS_STATUS 8'h04
`define EVPR_OFS_EN0 8'h08
`define EVPR_OFS_EN1 8'h0C
`define EVPR_OFS_PEND0 8'h10
`define EVPR_OFS_PEND1 8'h14
`define EVPR_OFS_PSET0 8'h18
`define EVPR_OFS_PSET1 8'h1C
`define EVPR_OFS_PCLR0 8'h20
`define EVPR_OFS_PCLR1 8'h24
`define EVPR_OFS_ACT0 8'h28
`define EVPR_OFS_ACT1 8'h2C
`define EVPR_OFS_QUERY 8'h30
`define EVPR_PRIO_REGION 2'h1

// ---------------------------------------------------------------
// Vector layout, masks and ranks
// ---------------------------------------------------------------
`define EVPR_IRQ_BASE 6'h10
`define EVPR_EXC_HARDFAULT 6'h03
`define EVPR_VBOR_MIN 32'h0000_0100
`define EVPR_VBOR_MAX 32'h3FFF_FF00
`define EVPR_VBOR_KEEP 32'h3FFF_FF00
`define EVPR_CFG_MASK 64'h0CBA_FFFF_C1FF_D870
`define EVPR_ARB_MASK 64'h0CBA_FFFF_C1FF_D87C
`define EVPR_IRQ_MASK 44'hCBA_FFFF_C1FF
`define EVPR_RANK_RESET 4'h0
`define EVPR_RANK_NMI 4'h1
`define EVPR_RANK_HARD 4'h2
`define EVPR_RANK_CFG_OFS 4'h3
`define EVPR_RESET_VEC 6'h01
`define EVPR_NMI_VEC 6'h02
`endif

/* hdl/evpr_pkg.sv */
package evpr_pkg;
   // Rank: fixed priority plus three, so -3 maps to 0
   typedef logic [3:0] evpr_rank_t;
   typedef logic [5:0] evpr_num_t;
   typedef logic [2:0] evpr_prio_t;
   // Per-exception life cycle
   typedef enum logic [1:0] {
      EVPR_INACTIVE = 2'b00,
      EVPR_PENDING = 2'b01,
      EVPR_ACTIVE = 2'b10,
      EVPR_ACT_PEND = 2'b11
   } evpr_state_t;
endpackage

/* hdl/evpr_sync.sv */
`timescale 1ns/1ns
module evpr_sync #(
   parameter int W = 44
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Async levels in, synchronised levels out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   // Two-stage level synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

/* hdl/evpr_prio_pick.sv */
`timescale 1ns/1ns
module evpr_prio_pick #(
   parameter int N = 64,
   parameter int RW = 4
) (
   // Candidates and their ranks
   input wire logic [N-1:0] req_i,
   input wire logic [N*RW-1:0] rank_i,
   // Winner
   output logic valid_o,
   output logic [$clog2(N)-1:0] num_o,
   output logic [RW-1:0] rank_o
);
   // Linear scan; strict compare keeps the lowest number on ties
   always_comb begin
      valid_o = 1'b0;
      num_o = '0;
      rank_o = '1;
      for (int i = 0; i < N; i++) begin
         if (req_i[i] && (!valid_o || rank_i[i*RW +: RW] < rank_o)) begin
            valid_o = 1'b1;
            num_o = ($clog2(N))'(i);
            rank_o = rank_i[i*RW +: RW];
         end
      end
   end
endmodule

/* hdl/evpr_top.sv */
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "evpr_cfg.svh"
module evpr_top #(
   parameter int NIRQ = 44
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Peripheral interrupt lines, asynchronous levels
   input wire logic [NIRQ-1:0] irq_i,
   // Core side system exception requests, one-cycle pulses
   input wire logic [15:0] sys_req_i,
   // Core handshake
   output logic take_o,
   output logic preempt_o,
   output evpr_pkg::evpr_num_t take_num_o,
   output logic [31:0] vector_addr_o,
   output logic [31:0] stack_ptr_addr_o,
   input wire logic entry_ack_i,
   input wire logic exc_done_i,
   input wire evpr_pkg::evpr_num_t exc_done_num_i
);
   import evpr_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [31:0] vector_base_offset_reg;
   logic [NIRQ-1:0] irq_en_reg;
   logic [63:0] pend_reg;
   logic [63:0] pend_next;
   logic [63:0] active_reg;
   logic [63:0] active_next;
   logic [255:0] rank_flat;
   evpr_prio_t prio_reg [64];
   evpr_num_t query_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic best_valid_reg;
   evpr_num_t best_num_reg;
   evpr_rank_t best_rank_reg;
   logic entry_hold_reg;
   logic [NIRQ-1:0] irq_sync;
   logic [63:0] enable_vec;
   logic [63:0] arb_req;
   logic best_valid;
   evpr_num_t best_num;
   evpr_rank_t best_rank;
   logic cur_valid;
   evpr_num_t cur_num;
   evpr_rank_t cur_rank;
   logic bus_req;
   logic bus_wr;
   logic [7:0] word_adr;
   logic [63:0] sw_set;
   logic [63:0] sw_clr;
   logic [63:0] hw_set;
   logic [63:0] entry_set;
   logic [63:0] done_clr;
   logic [31:0] vbor_wdata;
   evpr_state_t query_state;

   // Masks as named vectors so single bits and fields can be picked
   localparam logic [63:0] CFG_MASK = `EVPR_CFG_MASK;
   localparam logic [63:0] ARB_MASK = `EVPR_ARB_MASK;
   localparam logic [43:0] IRQ_MASK = `EVPR_IRQ_MASK;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   // Request held by the master; write lands on the ack edge
   assign bus_req = cyc_i && stb_i;
   assign bus_wr = bus_req && we_i && ack_reg;
   assign word_adr = {adr_i[7:2], 2'b00};
   assign ack_o = ack_reg;
   assign dat_o = rdata_reg;

   // Acknowledge one cycle after the request, drop the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req && !ack_reg;
      end
   end

   // ---------------------------------------------------------------
   // Vector table base
   // ---------------------------------------------------------------
   // Alignment bits and bits above the permitted range are dropped
   assign vbor_wdata = dat_i & `EVPR_VBOR_KEEP;

   // Base resets to zero; relocation only inside the permitted range
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vector_base_offset_reg <= 32'h0000_0000;
      end else if (bus_wr && word_adr == `EVPR_OFS_VBOR && sel_i == 4'hF) begin
         if (vbor_wdata >= `EVPR_VBOR_MIN && vbor_wdata <= `EVPR_VBOR_MAX) begin
            vector_base_offset_reg <= vbor_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Enables and query pointer
   // ---------------------------------------------------------------
   // Interrupt enables, one bit per peripheral line
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_reg <= '0;
      end else if (bus_wr && word_adr == `EVPR_OFS_EN0) begin
         irq_en_reg[31:0] <= dat_i & IRQ_MASK[31:0];
      end else if (bus_wr && word_adr == `EVPR_OFS_EN1) begin
         irq_en_reg[NIRQ-1:32] <= dat_i[NIRQ-33:0] & IRQ_MASK[NIRQ-1:32];
      end
   end

   // Exception number whose state is read back
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         query_reg <= '0;
      end else if (bus_wr && word_adr == `EVPR_OFS_QUERY) begin
         query_reg <= dat_i[5:0];
      end
   end

   // ---------------------------------------------------------------
   // Priority storage, one three-bit field per exception
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_prio
         // Only configurable, non-reserved entries take writes
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               prio_reg[g] <= 3'h0;
            end else if (bus_wr && adr_i[7:6] == `EVPR_PRIO_REGION && adr_i[5:2] == 4'(g / 4)
                         && sel_i[g % 4] && CFG_MASK[g]) begin
               prio_reg[g] <= dat_i[(g % 4) * 8 +: 3];
            end
         end

         // Fixed ranks for reset, NMI, hard fault; others offset by three
         always_comb begin
            if (g == `EVPR_RESET_VEC) begin
               rank_flat[g*4 +: 4] = `EVPR_RANK_RESET;
            end else if (g == `EVPR_NMI_VEC) begin
               rank_flat[g*4 +: 4] = `EVPR_RANK_NMI;
            end else if (g == `EVPR_EXC_HARDFAULT) begin
               rank_flat[g*4 +: 4] = `EVPR_RANK_HARD;
            end else begin
               rank_flat[g*4 +: 4] = {1'b0, prio_reg[g]} + `EVPR_RANK_CFG_OFS;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Request sources
   // ---------------------------------------------------------------
   evpr_sync #(
      .W(NIRQ)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(irq_i),
      .q_o(irq_sync)
   );

   // Peripheral n lands on exception n+16; system ones keep their number
   always_comb begin
      hw_set = '0;
      hw_set[15:0] = sys_req_i;
      hw_set[`EVPR_IRQ_BASE +: NIRQ] = irq_sync;
      hw_set = hw_set & `EVPR_ARB_MASK;
   end

   // Software set and clear of pending bits
   always_comb begin
      sw_set = '0;
      sw_clr = '0;
      if (bus_wr && word_adr == `EVPR_OFS_PSET0) begin
         sw_set[31:0] = dat_i;
      end
      if (bus_wr && word_adr == `EVPR_OFS_PSET1) begin
         sw_set[63:32] = dat_i;
      end
      if (bus_wr && word_adr == `EVPR_OFS_PCLR0) begin
         sw_clr[31:0] = dat_i;
      end
      if (bus_wr && word_adr == `EVPR_OFS_PCLR1) begin
         sw_clr[63:32] = dat_i;
      end
   end

   // Entry moves the presented exception to active; return clears it
   always_comb begin
      entry_set = '0;
      done_clr = '0;
      if (entry_ack_i && take_o) begin
         entry_set[take_num_o] = 1'b1;
      end
      if (exc_done_i) begin
         done_clr[exc_done_num_i] = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Pending and active tracking
   // ---------------------------------------------------------------
   // New requests win over clears, giving active-and-pending
   assign pend_next = ((pend_reg & ~sw_clr & ~entry_set) | hw_set | sw_set) & `EVPR_ARB_MASK;
   assign active_next = (active_reg & ~done_clr) | entry_set;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= pend_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_reg <= '0;
      end else begin
         active_reg <= active_next;
      end
   end

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   // NMI and the other system exceptions cannot be disabled here
   always_comb begin
      enable_vec = '0;
      enable_vec[15:0] = ARB_MASK[15:0];
      enable_vec[`EVPR_IRQ_BASE +: NIRQ] = irq_en_reg;
   end
   assign arb_req = pend_reg & enable_vec;

   // Best pending, lowest number on equal rank
   evpr_prio_pick #(
      .N(64),
      .RW(4)
   ) u_pend_pick (
      .req_i(arb_req),
      .rank_i(rank_flat),
      .valid_o(best_valid),
      .num_o(best_num),
      .rank_o(best_rank)
   );

   // Running level is the best of the active set
   evpr_prio_pick #(
      .N(64),
      .RW(4)
   ) u_act_pick (
      .req_i(active_reg),
      .rank_i(rank_flat),
      .valid_o(cur_valid),
      .num_o(cur_num),
      .rank_o(cur_rank)
   );

   // Winner registered every cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         best_valid_reg <= 1'b0;
         best_num_reg <= '0;
         best_rank_reg <= '1;
      end else begin
         best_valid_reg <= best_valid;
         best_num_reg <= best_num;
         best_rank_reg <= best_rank;
      end
   end

   // Blank the offer one cycle after an entry while the winner refreshes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         entry_hold_reg <= 1'b0;
      end else begin
         entry_hold_reg <= entry_ack_i && take_o;
      end
   end

   // ---------------------------------------------------------------
   // Core outputs
   // ---------------------------------------------------------------
   // Preempt only on strictly better rank; equal rank stays pending
   assign preempt_o = best_valid_reg && !entry_hold_reg && cur_valid && best_rank_reg < cur_rank;
   assign take_o = best_valid_reg && !entry_hold_reg && (!cur_valid || best_rank_reg < cur_rank);
   assign take_num_o = best_num_reg;

   // Handler fetch address base + 4 * vector; entry zero holds the stack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vector_addr_o <= 32'h0000_0000;
         stack_ptr_addr_o <= 32'h0000_0000;
      end else begin
         vector_addr_o <= vector_base_offset_reg + {24'h00_0000, best_num, 2'b00};
         stack_ptr_addr_o <= vector_base_offset_reg;
      end
   end

   // ---------------------------------------------------------------
   // Read back
   // ---------------------------------------------------------------
   assign query_state = evpr_state_t'({active_reg[query_reg], pend_reg[query_reg]});

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (adr_i[7:6] == `EVPR_PRIO_REGION) begin
         for (int j = 0; j < 4; j++) begin
            rdata_next[j*8 +: 3] = prio_reg[{adr_i[5:2], 2'(j)}];
         end
      end else begin
         case (word_adr)
            `EVPR_OFS_VBOR: rdata_next = vector_base_offset_reg;
            `EVPR_OFS_STATUS: rdata_next = {16'h0000, take_o, cur_valid, cur_num, 2'b00, best_num_reg};
            `EVPR_OFS_EN0: rdata_next = irq_en_reg[31:0];
            `EVPR_OFS_EN1: rdata_next[NIRQ-33:0] = irq_en_reg[NIRQ-1:32];
            `EVPR_OFS_PEND0: rdata_next = pend_reg[31:0];
            `EVPR_OFS_PEND1: rdata_next = pend_reg[63:32];
            `EVPR_OFS_ACT0: rdata_next = active_reg[31:0];
            `EVPR_OFS_ACT1: rdata_next = active_reg[63:32];
            `EVPR_OFS_QUERY: rdata_next = {22'h00_0000, query_state, 2'b00, query_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Read data captured with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (bus_req && !ack_reg) begin
         rdata_reg <= rdata_next;
      end
   end
endmodule

/* tb/evpr_monitor.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Checker on the resolver ports
// ---------------------------------------------------------------
module evpr_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus handshake
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // Core side
   input wire logic [15:0] sys_req_i,
   input wire logic take_o,
   input wire logic preempt_o,
   input wire evpr_pkg::evpr_num_t take_num_o,
   input wire logic [31:0] vector_addr_o,
   input wire logic [31:0] stack_ptr_addr_o,
   input wire logic entry_ack_i
);
   import evpr_pkg::*;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Steps of a bus request and of an undisturbed NMI request
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_nmi_req;
      sys_req_i[2] && !entry_ack_i ##1 !entry_ack_i;
   endsequence
   property p_ack_next;
      s_req |=> ack_o;
   endproperty
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   property p_reset_base;
      $fell(rst_i) |-> stack_ptr_addr_o == 32'h0000_0000 && !take_o;
   endproperty
   property p_vec;
      take_o |-> vector_addr_o == stack_ptr_addr_o + {24'h000000, take_num_o, 2'b00};
   endproperty
   property p_base_ok;
      stack_ptr_addr_o[7:0] == 8'h00 && stack_ptr_addr_o[31:30] == 2'h0;
   endproperty
   property p_preempt;
      preempt_o |-> take_o;
   endproperty
   property p_reserved;
      take_o |-> !(take_num_o inside {[6'h00:6'h01], [6'h07:6'h0A], 6'h0D, [6'h19:6'h1D], 6'h30, 6'h32, 6'h36,
         [6'h38:6'h39], [6'h3C:6'h3F]});
   endproperty
   property p_blank;
      entry_ack_i && take_o |=> !take_o;
   endproperty
   property p_nmi;
      s_nmi_req |=> take_o && take_num_o == 6'h02;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_reset_base: assert property (p_reset_base) else $error("table base not zero after reset");
   a_vec: assert property (p_vec) else $error("vector address off");
   a_base_ok: assert property (p_base_ok) else $error("table base out of range");
   a_preempt: assert property (p_preempt) else $error("preempt without offer");
   a_reserved: assert property (p_reserved) else $error("reserved number offered");
   a_blank: assert property (p_blank) else $error("offer kept after entry");
   a_nmi: assert property (p_nmi) else $error("NMI not offered");
endmodule
bind evpr_top evpr_monitor evpr_monitor_i (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .sys_req_i, .take_o,
   .preempt_o, .take_num_o, .vector_addr_o, .stack_ptr_addr_o, .entry_ack_i);

/* tb/evpr_core_model.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Core model: enters offers on command, returns innermost first
// ---------------------------------------------------------------
module evpr_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Offer from the resolver
   input wire logic take_i,
   input wire evpr_pkg::evpr_num_t num_i,
   // Bench commands
   input wire logic go_i,
   input wire logic ret_i,
   input wire logic [3:0] wait_i,
   // Entry and return
   output logic entry_ack_o,
   output logic exc_done_o,
   output evpr_pkg::evpr_num_t done_num_o
);
   import evpr_pkg::*;
   evpr_num_t stk [8];
   int sp;
   int cnt;
   logic armed;
   logic ack_n;
   logic done_n;
   // Entry after a chosen delay, nesting stack, return
   always @(posedge clk_i) begin
      ack_n = 1'b0;
      done_n = 1'b0;
      if (rst_i) begin
         sp = 0;
         cnt = 0;
         armed = 1'b0;
         done_num_o <= '0;
      end else begin
         if (go_i) begin
            armed = 1'b1;
         end
         if (entry_ack_o && take_i) begin
            stk[sp] = num_i;
            sp++;
            armed = 1'b0;
         end else if (armed && take_i && !entry_ack_o) begin
            if (cnt < wait_i) begin
               cnt++;
            end else begin
               cnt = 0;
               ack_n = 1'b1;
            end
         end
         if (ret_i && sp > 0) begin
            sp--;
            done_n = 1'b1;
            done_num_o <= stk[sp];
         end
      end
      // Each output assigned once per edge
      entry_ack_o <= ack_n;
      exc_done_o <= done_n;
   end
endmodule

/* tb/exception_vector_priority_resolver_test.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Bench for the resolver
// ---------------------------------------------------------------
module exception_vector_priority_resolver_test;
   import evpr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, go_i = 1'b0, ret_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0, wait_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, vector_addr_o, stack_ptr_addr_o, rd, bv;
   logic [43:0] irq_i = 44'h0;
   logic [15:0] sys_req_i = 16'h0;
   logic ack_o, take_o, preempt_o, entry_ack_i, exc_done_i;
   evpr_num_t take_num_o, exc_done_num_i;
   int bad_count = 0, num_checks = 0;
   // Clock
   initial forever #25 clk_i = ~clk_i;
   evpr_top evpr_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_i,
      .sys_req_i, .take_o, .preempt_o, .take_num_o, .vector_addr_o, .stack_ptr_addr_o, .entry_ack_i, .exc_done_i,
      .exc_done_num_i);
   evpr_core_model evpr_core_model_i (.clk_i, .rst_i, .take_i(take_o), .num_i(take_num_o), .go_i, .ret_i, .wait_i,
      .entry_ack_o(entry_ack_i), .exc_done_o(exc_done_i), .done_num_o(exc_done_num_i));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic expire(input string nm);
      chk(nm, 32'h0, 32'h1);
      conclude();
   endtask
   // One classic bus cycle; read data lands in rd
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      @(posedge clk_i);
      while (ack_o !== 1'b1) begin
         if (++n > 20) expire("ack wait");
         @(posedge clk_i);
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   // Wait for an offer, check it, let the core enter it
   task automatic enter(input logic [5:0] num, input logic pre);
      int n;
      n = 0;
      while (take_o !== 1'b1) begin
         if (++n > 30) expire("offer wait");
         @(posedge clk_i);
      end
      chk("offered number", take_num_o, num);
      chk("vector", vector_addr_o, bv + {24'h000000, num, 2'b00});
      chk("preempt", preempt_o, pre);
      go_i <= 1'b1;
      @(posedge clk_i);
      go_i <= 1'b0;
      while (!(entry_ack_i === 1'b1 && take_o === 1'b1)) begin
         if (++n > 40) expire("entry wait");
         @(posedge clk_i);
      end
      @(posedge clk_i);
   endtask
   task automatic leave;
      ret_i <= 1'b1;
      @(posedge clk_i);
      ret_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic hush(input string nm);
      logic s;
      s = 1'b0;
      repeat (8) begin
         @(posedge clk_i);
         s = s | take_o;
      end
      chk(nm, s, 1'b0);
   endtask
   task automatic sys(input logic [15:0] r);
      sys_req_i <= r;
      @(posedge clk_i);
      sys_req_i <= 16'h0000;
   endtask
   // Main sequence
   initial begin
      bv = 32'h0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk("base", 8'h00, 32'h0);
      chk("table top", stack_ptr_addr_o, 32'h0);
      rchk("prio default", 8'h44, 32'h0);
      rchk("unmapped", 8'h34, 32'h0);
      $display("test reset done");
      wb(1'b1, 8'h00, 32'h0000_0100);
      rchk("base low", 8'h00, 32'h0000_0100);
      wb(1'b1, 8'h00, 32'h4000_0000);
      rchk("base kept", 8'h00, 32'h0000_0100);
      wb(1'b1, 8'h00, 32'h3FFF_FF00);
      rchk("base high", 8'h00, 32'h3FFF_FF00);
      wb(1'b1, 8'h00, 32'h0000_0200);
      bv = 32'h0000_0200;
      rchk("base", 8'h00, bv);
      chk("table top", stack_ptr_addr_o, bv);
      wb(1'b1, 8'h44, 32'hFFFF_FFFF);
      rchk("prio width", 8'h44, 32'h0007_0707);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      rchk("fixed prio", 8'h40, 32'h0);
      wb(1'b1, 8'h44, 32'h0);
      $display("test registers done");
      wb(1'b1, 8'h18, 32'h0000_C000);
      enter(6'h0E, 1'b0);
      hush("equal offer");
      leave();
      enter(6'h0F, 1'b0);
      leave();
      wb(1'b1, 8'h4C, 32'h0500_0000);
      wb(1'b1, 8'h18, 32'h0000_8000);
      enter(6'h0F, 1'b0);
      wb(1'b1, 8'h18, 32'h0000_4000);
      enter(6'h0E, 1'b1);
      rchk("both active", 8'h28, 32'h0000_C000);
      wb(1'b1, 8'h30, 32'h0000_000E);
      rchk("query active", 8'h30, 32'h0000_020E);
      leave();
      leave();
      $display("test ranking done");
      wb(1'b1, 8'h08, 32'hFFFF_FFFF);
      rchk("enable low", 8'h08, 32'hFFFF_C1FF);
      wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      rchk("enable high", 8'h0C, 32'h0000_0CBA);
      irq_i <= 44'h000_0000_0201;
      enter(6'h10, 1'b0);
      irq_i <= 44'h0;
      repeat (4) @(posedge clk_i);
      wb(1'b1, 8'h30, 32'h0000_0010);
      rchk("query both", 8'h30, 32'h0000_0310);
      wb(1'b1, 8'h20, 32'h0001_0000);
      leave();
      irq_i <= 44'h800_0000_0000;
      enter(6'h3B, 1'b0);
      irq_i <= 44'h0;
      repeat (4) @(posedge clk_i);
      wb(1'b1, 8'h24, 32'h0800_0000);
      leave();
      irq_i <= 44'h000_0000_3E00;
      hush("reserved offer");
      irq_i <= 44'h0;
      $display("test lines done");
      wait_i <= 4'h3;
      wb(1'b1, 8'h18, 32'h0000_8000);
      enter(6'h0F, 1'b0);
      sys(16'h0008);
      enter(6'h03, 1'b1);
      sys(16'h0004);
      enter(6'h02, 1'b1);
      leave();
      leave();
      leave();
      $display("test fixed done");
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("table top", stack_ptr_addr_o, 32'h0);
      rchk("base", 8'h00, 32'h0);
      $display("test second reset done");
      conclude();
   end
endmodule
